// ==== amfs_frame_sequencer.sv ====
// converter input frame sequencer with apb register file
`timescale 1ns/1ps

//Function
// - advance only on slow clock rising edges
// - drive mux, filter start, chop, compute pass
// - slot length from decimation, rate, pll
// - frame length adds pll tail to slots
// - report frame length in filter clocks
// - documented setups give thirteen-cycle frames
// - four-bit handle per slot, indexed by slot
// - slot count field sets active slots
// - pair a differential writes word zero only
// - pair b lands in word two only
// - voltage handles write their own words
// - remote samples bypass mux, slot two dropped
// - remote capture at mid frame
// - half rate bit selects converter speed
// - half rate decimation one doubles slot
// - frame starts at first slot, counts exactly
// - no more than eleven slots per frame
module amfs_frame_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow_32k_clock,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] slot_input_select,
    output logic filter_start,
    output logic compute_start,
    output logic reference_chop_phase,
    output logic result_write,
    output logic [3:0] result_ram_address,
    output logic result_from_remote,
    output logic pair_a_differential,
    output logic pair_b_differential,
    output logic remote_sensor_enable,
    output logic converter_half_rate,
    output logic fast_pll_select,
    output logic frame_active
);

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [7:0] slot_count_reg;
        logic [7:0] sel_8_9;
        logic [7:0] sel_6_7;
        logic [7:0] sel_4_5;
        logic [7:0] sel_2_3;
        logic [7:0] sel_0_1;
        logic [7:0] chop;
        logic [7:0] mode;
        logic [7:0] rate;
        logic [7:0] remote;
        amfs_pkg::amfs_seq_type seq;
        logic [3:0] slot;
        logic [4:0] slot_cyc;
        logic [1:0] tail_cyc;
        logic [8:0] frame_cyc;
        logic [3:0] act_slots;
        logic [4:0] act_slot_len;
        logic [1:0] act_tail;
        logic [8:0] act_frame_len;
        logic [15:0] act_filter_len;
        logic [43:0] act_sel;
        logic act_diff_a;
        logic act_diff_b;
        logic act_remote;
        logic act_half;
        logic act_fast;
        logic [3:0] handle;
        logic filter_start;
        logic compute_start;
        logic chop_phase;
        logic result_write;
        logic [3:0] result_addr;
        logic result_remote;
        logic remote_pending;
        logic active;
        logic pready;
        logic pslverr;
        logic [15:0] prdata;
    } amfs_state_type;

    amfs_state_type r;
    amfs_state_type next_r;
    logic slow_tick;

    // slow clock comes from another domain, so it is filtered first
    amfs_sync3 u_slow_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(slow_32k_clock),
        .level(),
        .rise(slow_tick)
    );

    // =====================================================================
    // configuration arithmetic, from the live registers
    // =====================================================================
    logic [1:0] cfg_decim;
    logic cfg_half;
    logic cfg_fast;
    logic [3:0] cfg_slots;
    logic [4:0] cfg_base;
    logic [4:0] cfg_slot_len;
    logic [1:0] cfg_tail;
    logic [8:0] cfg_frame_len;
    logic [15:0] cfg_filter_len;
    logic [43:0] cfg_sel;

    always_comb begin
        cfg_decim = r.mode[amfs_pkg::DECIM_LSB +: 2];
        cfg_half = r.rate[amfs_pkg::HALF_RATE_BIT];
        cfg_fast = r.rate[amfs_pkg::FAST_PLL_BIT];
        cfg_slots = r.slot_count_reg[amfs_pkg::SLOTS_LSB +: 4];
        if (cfg_slots > amfs_pkg::MAX_SLOTS) begin
            cfg_slots = amfs_pkg::MAX_SLOTS;
        end
        // doubling for half rate is the (half_rate+1) factor
        cfg_base = 5'((5'(cfg_decim) + 5'd1) << cfg_half);
        cfg_slot_len = cfg_fast ? cfg_base
                                : 5'(cfg_base * amfs_pkg::SLOW_PLL_FACTOR);
        cfg_tail = cfg_fast ? amfs_pkg::TAIL_FAST_PLL : amfs_pkg::TAIL_SLOW_PLL;
        cfg_frame_len = 9'(9'(cfg_slot_len) * 9'(cfg_slots)) + 9'(cfg_tail);
        cfg_filter_len = 16'(16'(cfg_frame_len)
                         * (cfg_fast ? amfs_pkg::FILTER_PER_SLOW_FAST_PLL
                                     : amfs_pkg::FILTER_PER_SLOW_SLOW_PLL));
        cfg_sel = {r.slot_count_reg[3:0], r.sel_8_9, r.sel_6_7, r.sel_4_5,
                   r.sel_2_3, r.sel_0_1};
    end

    // =====================================================================
    // register read data
    // =====================================================================
    logic [15:0] rd_data;
    logic rd_hit;
    logic wr_ok;

    always_comb begin
        rd_hit = 1'b1;
        wr_ok = 1'b1;
        rd_data = 16'h0000;
        unique case (paddr)
            amfs_pkg::ADDR_SLOT_COUNT: rd_data = {8'h00, r.slot_count_reg};
            amfs_pkg::ADDR_SEL_8_9: rd_data = {8'h00, r.sel_8_9};
            amfs_pkg::ADDR_SEL_6_7: rd_data = {8'h00, r.sel_6_7};
            amfs_pkg::ADDR_SEL_4_5: rd_data = {8'h00, r.sel_4_5};
            amfs_pkg::ADDR_SEL_2_3: rd_data = {8'h00, r.sel_2_3};
            amfs_pkg::ADDR_SEL_0_1: rd_data = {8'h00, r.sel_0_1};
            amfs_pkg::ADDR_CHOP: rd_data = {8'h00, r.chop};
            amfs_pkg::ADDR_MODE: rd_data = {8'h00, r.mode};
            amfs_pkg::ADDR_RATE: rd_data = {8'h00, r.rate};
            amfs_pkg::ADDR_REMOTE: rd_data = {8'h00, r.remote};
            amfs_pkg::ADDR_STATUS: begin
                rd_data = {6'h00, r.chop_phase, r.seq != amfs_pkg::seq_idle,
                           r.handle, r.slot};
                wr_ok = 1'b0;
            end
            amfs_pkg::ADDR_FRAME_SLOW: begin
                rd_data = {7'h00, r.act_frame_len};
                wr_ok = 1'b0;
            end
            amfs_pkg::ADDR_FRAME_FILTER: begin
                rd_data = r.act_filter_len;
                wr_ok = 1'b0;
            end
            default: begin
                rd_hit = 1'b0;
                wr_ok = 1'b0;
            end
        endcase
    end

    // =====================================================================
    // next state
    // =====================================================================
    logic frame_begin;
    logic slot_end;
    logic [3:0] cur_handle;
    logic [3:0] first_handle;
    logic [3:0] next_handle;
    logic keep_result;
    logic [8:0] next_frame_cyc;

    always_comb begin
        next_r = r;
        frame_begin = 1'b0;
        slot_end = 1'b0;
        keep_result = 1'b0;
        next_frame_cyc = 9'(r.frame_cyc + 9'd1);
        cur_handle = r.act_sel[{r.slot, 2'b00} +: 4];
        first_handle = cfg_sel[3:0];
        next_handle = r.act_sel[{4'(r.slot + 4'd1), 2'b00} +: 4];
        next_r.filter_start = 1'b0;
        next_r.compute_start = 1'b0;
        next_r.result_write = 1'b0;
        next_r.result_remote = 1'b0;

        // apb slave: answer in the cycle after setup
        next_r.pready = psel & ~penable;
        // error flag stands only with pready, never after the access
        next_r.pslverr = 1'b0;
        if (psel && !penable) begin
            next_r.prdata = pwrite ? 16'h0000 : rd_data;
            next_r.pslverr = ~rd_hit;
        end
        if (psel && penable && r.pready && pwrite && wr_ok) begin
            unique case (paddr)
                amfs_pkg::ADDR_SLOT_COUNT: next_r.slot_count_reg = pwdata[7:0];
                amfs_pkg::ADDR_SEL_8_9: next_r.sel_8_9 = pwdata[7:0];
                amfs_pkg::ADDR_SEL_6_7: next_r.sel_6_7 = pwdata[7:0];
                amfs_pkg::ADDR_SEL_4_5: next_r.sel_4_5 = pwdata[7:0];
                amfs_pkg::ADDR_SEL_2_3: next_r.sel_2_3 = pwdata[7:0];
                amfs_pkg::ADDR_SEL_0_1: next_r.sel_0_1 = pwdata[7:0];
                amfs_pkg::ADDR_CHOP: next_r.chop = pwdata[7:0];
                amfs_pkg::ADDR_MODE: next_r.mode = pwdata[7:0];
                amfs_pkg::ADDR_RATE: next_r.rate = pwdata[7:0];
                amfs_pkg::ADDR_REMOTE: next_r.remote = pwdata[7:0];
                default: next_r.remote = r.remote;
            endcase
        end

        // remote word lands two cycles after the mid-frame slow tick, one after any slot result of that tick, so they never collide
        if (r.remote_pending) begin
            next_r.remote_pending = 1'b0;
            next_r.result_write = 1'b1;
            next_r.result_remote = 1'b1;
            next_r.result_addr = amfs_pkg::HANDLE_B_PLUS;
        end

        if (slow_tick) begin
            unique case (r.seq)
                amfs_pkg::seq_idle: frame_begin = cfg_slots != 4'h0;
                amfs_pkg::seq_slot: begin
                    next_r.frame_cyc = next_frame_cyc;
                    if (r.slot_cyc == r.act_slot_len) begin
                        slot_end = 1'b1;
                        if (4'(r.slot + 4'd1) == r.act_slots) begin
                            next_r.seq = amfs_pkg::seq_tail;
                            next_r.tail_cyc = 2'd1;
                        end else begin
                            next_r.slot = 4'(r.slot + 4'd1);
                            next_r.slot_cyc = 5'd1;
                            next_r.handle = next_handle;
                            next_r.filter_start = 1'b1;
                        end
                    end else begin
                        next_r.slot_cyc = 5'(r.slot_cyc + 5'd1);
                    end
                end
                amfs_pkg::seq_tail: begin
                    next_r.frame_cyc = next_frame_cyc;
                    if (r.tail_cyc == r.act_tail) begin
                        frame_begin = cfg_slots != 4'h0;
                        if (!frame_begin) begin
                            next_r.seq = amfs_pkg::seq_idle;
                        end
                    end else begin
                        next_r.tail_cyc = 2'(r.tail_cyc + 2'd1);
                    end
                end
            endcase
        end

        // slot results: pair minus handles and remote-owned slot are discarded
        if (slot_end) begin
            keep_result = 1'b1;
            if (r.act_diff_a && cur_handle == amfs_pkg::HANDLE_A_MINUS) begin
                keep_result = 1'b0;
            end
            if ((r.act_diff_b || r.act_remote) && cur_handle == amfs_pkg::HANDLE_B_MINUS) begin
                keep_result = 1'b0;
            end
            if (r.act_remote && r.slot == amfs_pkg::REMOTE_SLOT) begin
                keep_result = 1'b0;
            end
            next_r.result_write = keep_result;
            next_r.result_remote = 1'b0;
            next_r.result_addr = cur_handle;
        end

        // configuration is captured only here, never mid-slot
        if (frame_begin) begin
            next_r.seq = amfs_pkg::seq_slot;
            next_r.slot = 4'h0;
            next_r.slot_cyc = 5'd1;
            next_r.frame_cyc = 9'd1;
            next_r.act_slots = cfg_slots;
            next_r.act_slot_len = cfg_slot_len;
            next_r.act_tail = cfg_tail;
            next_r.act_frame_len = cfg_frame_len;
            next_r.act_filter_len = cfg_filter_len;
            next_r.act_sel = cfg_sel;
            next_r.act_diff_a = r.mode[amfs_pkg::DIFF_A_BIT];
            next_r.act_diff_b = r.mode[amfs_pkg::DIFF_B_BIT];
            next_r.act_remote = r.remote[amfs_pkg::REMOTE_BIT];
            next_r.act_half = cfg_half;
            next_r.act_fast = cfg_fast;
            next_r.handle = first_handle;
            next_r.filter_start = 1'b1;
            next_r.compute_start = 1'b1;
            unique case (r.chop[amfs_pkg::CHOP_LSB +: 2])
                2'b00: next_r.chop_phase = 1'b0;
                2'b01: next_r.chop_phase = 1'b1;
                default: next_r.chop_phase = ~r.chop_phase;
            endcase
        end

        // remote capture point: half way through the running frame
        if (slow_tick && next_r.seq != amfs_pkg::seq_idle && next_r.act_remote
            && next_r.frame_cyc == (next_r.act_frame_len >> 1)) begin
            next_r.remote_pending = 1'b1;
        end
        next_r.active = next_r.seq != amfs_pkg::seq_idle;
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.slot_count_reg <= amfs_pkg::REG_RESET;
            r.seq <= amfs_pkg::seq_idle;
        end else begin
            r <= next_r;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign prdata = {16'h0000, r.prdata};
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign slot_input_select = r.handle;
    assign filter_start = r.filter_start;
    assign compute_start = r.compute_start;
    assign reference_chop_phase = r.chop_phase;
    assign result_write = r.result_write;
    assign result_ram_address = r.result_addr;
    assign result_from_remote = r.result_remote;
    assign pair_a_differential = r.act_diff_a;
    assign pair_b_differential = r.act_diff_b;
    assign remote_sensor_enable = r.act_remote;
    assign converter_half_rate = r.act_half;
    assign fast_pll_select = r.act_fast;
    assign frame_active = r.active;

endmodule // amfs_frame_sequencer

// ==== amfs_pkg.sv ====
// shared constants and types of the converter frame sequencer
package amfs_pkg;

    // =====================================================================
    // register indices (byte address is four times the index)
    // =====================================================================
    localparam logic [13:0] IDX_SLOT_COUNT = 14'h2100;
    localparam logic [13:0] IDX_SEL_8_9 = 14'h2101;
    localparam logic [13:0] IDX_SEL_6_7 = 14'h2102;
    localparam logic [13:0] IDX_SEL_4_5 = 14'h2103;
    localparam logic [13:0] IDX_SEL_2_3 = 14'h2104;
    localparam logic [13:0] IDX_SEL_0_1 = 14'h2105;
    localparam logic [13:0] IDX_CHOP = 14'h2106;
    localparam logic [13:0] IDX_MODE = 14'h210c;
    localparam logic [13:0] IDX_RATE = 14'h2200;
    localparam logic [13:0] IDX_REMOTE = 14'h2709;
    localparam logic [13:0] IDX_STATUS = 14'h2110;
    localparam logic [13:0] IDX_FRAME_SLOW = 14'h2111;
    localparam logic [13:0] IDX_FRAME_FILTER = 14'h2112;

    localparam logic [15:0] ADDR_SLOT_COUNT = {IDX_SLOT_COUNT, 2'b00};
    localparam logic [15:0] ADDR_SEL_8_9 = {IDX_SEL_8_9, 2'b00};
    localparam logic [15:0] ADDR_SEL_6_7 = {IDX_SEL_6_7, 2'b00};
    localparam logic [15:0] ADDR_SEL_4_5 = {IDX_SEL_4_5, 2'b00};
    localparam logic [15:0] ADDR_SEL_2_3 = {IDX_SEL_2_3, 2'b00};
    localparam logic [15:0] ADDR_SEL_0_1 = {IDX_SEL_0_1, 2'b00};
    localparam logic [15:0] ADDR_CHOP = {IDX_CHOP, 2'b00};
    localparam logic [15:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [15:0] ADDR_RATE = {IDX_RATE, 2'b00};
    localparam logic [15:0] ADDR_REMOTE = {IDX_REMOTE, 2'b00};
    localparam logic [15:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [15:0] ADDR_FRAME_SLOW = {IDX_FRAME_SLOW, 2'b00};
    localparam logic [15:0] ADDR_FRAME_FILTER = {IDX_FRAME_FILTER, 2'b00};

    // =====================================================================
    // field positions and reset values
    // =====================================================================
    localparam int SLOTS_LSB = 4;
    localparam int CHOP_LSB = 2;
    localparam int DECIM_LSB = 1;
    localparam int DIFF_A_BIT = 4;
    localparam int DIFF_B_BIT = 5;
    localparam int HALF_RATE_BIT = 5;
    localparam int FAST_PLL_BIT = 4;
    localparam int REMOTE_BIT = 3;
    localparam logic [7:0] REG_RESET = 8'h00;

    // =====================================================================
    // sequencing figures
    // =====================================================================
    localparam logic [3:0] MAX_SLOTS = 4'h0b;
    localparam logic [3:0] REMOTE_SLOT = 4'h2;
    localparam logic [3:0] HANDLE_A_MINUS = 4'h1;
    localparam logic [3:0] HANDLE_B_PLUS = 4'h2;
    localparam logic [3:0] HANDLE_B_MINUS = 4'h3;
    localparam logic [4:0] SLOW_PLL_FACTOR = 5'h03;
    localparam logic [1:0] TAIL_SLOW_PLL = 2'h3;
    localparam logic [1:0] TAIL_FAST_PLL = 2'h1;
    localparam logic [15:0] FILTER_PER_SLOW_SLOW_PLL = 16'h0030;
    localparam logic [15:0] FILTER_PER_SLOW_FAST_PLL = 16'h0096;

    typedef enum logic [1:0] {
        seq_idle,
        seq_slot,
        seq_tail
    } amfs_seq_type;

endpackage

// ==== amfs_sync3.sv ====
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps

module amfs_sync3 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic level,
    output logic rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } amfs_sync_type;

    amfs_sync_type r;
    amfs_sync_type next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // a change only counts once stages two and three agree
        if (r.s2 == r.s3) begin
            next_r.lvl = r.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.lvl;
    assign rise = r.s2 & r.s3 & ~r.lvl;

endmodule // amfs_sync3

// ==== amfs_seq_props.sv ====
// concurrent checks on the frame sequencer ports
`timescale 1ns/1ps
module amfs_seq_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] slot_input_select,
    input wire logic filter_start,
    input wire logic compute_start,
    input wire logic result_write,
    input wire logic [3:0] result_ram_address,
    input wire logic result_from_remote,
    input wire logic pair_a_differential,
    input wire logic pair_b_differential,
    input wire logic remote_sensor_enable,
    input wire logic fast_pll_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================
    // named steps
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_slot_quiet;
        !filter_start [*8];
    endsequence
    // ========================================
    // register bus
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // ========================================
    // sequencing
    // a slot lasts at least one slow tick, far more than eight pclk
    a_slot_spacing: assert property (filter_start |=> s_slot_quiet)
        else $error("slot start too soon after previous");
    a_frame_first_slot: assert property (compute_start |-> filter_start)
        else $error("frame start without slot start");
    a_select_at_slot: assert property ($changed(slot_input_select) |-> filter_start)
        else $error("select moved mid slot");
    a_config_at_frame: assert property ($changed({pair_a_differential, pair_b_differential,
        remote_sensor_enable, fast_pll_select}) |-> compute_start)
        else $error("configuration changed mid frame");
    a_word_one_kept: assert property (result_write && pair_a_differential
        |-> result_ram_address != amfs_pkg::HANDLE_A_MINUS)
        else $error("word one written in pair a mode");
    a_word_three_kept: assert property (result_write && (pair_b_differential
        || remote_sensor_enable) |-> result_ram_address != amfs_pkg::HANDLE_B_MINUS)
        else $error("word three written in pair b mode");
    a_remote_word: assert property (result_from_remote |-> result_write && remote_sensor_enable
        && result_ram_address == amfs_pkg::HANDLE_B_PLUS)
        else $error("remote sample misplaced");
endmodule // amfs_seq_props

bind amfs_frame_sequencer amfs_seq_props i_props (.*);

// ==== amfs_engine_model.sv ====
// behavioural compute engine: notes result words and counts passes
`timescale 1ns/1ps
module amfs_engine_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic compute_start,
    input wire logic result_write,
    input wire logic [3:0] result_ram_address,
    output logic [15:0] written_words,
    output logic [7:0] pass_count
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_words <= 16'h0000;
            pass_count <= 8'h00;
        end else begin
            if (compute_start) begin
                pass_count <= pass_count + 8'h01;
            end
            // a word once written stays marked, so untouched words stand out
            if (result_write) begin
                written_words[result_ram_address] <= 1'b1;
            end
        end
    end
endmodule // amfs_engine_model

// ==== testbench.sv ====
// self-checking bench for the converter frame sequencer
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic slow_32k_clock = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, filter_start, compute_start, reference_chop_phase, result_write;
    logic result_from_remote, pair_a_differential, pair_b_differential, remote_sensor_enable;
    logic converter_half_rate, fast_pll_select, frame_active;
    logic [3:0] slot_input_select, result_ram_address;
    logic [15:0] written_words;
    logic [7:0] pass_count;
    logic [4:0] exp_q[$];
    int error_cnt = 0;
    int check_count = 0;
    integer seed = 32'hf7ea;
    logic [31:0] rd, r;
    logic er;

    amfs_frame_sequencer i_dut (.*);
    amfs_engine_model i_model (.pclk(pclk), .presetn(presetn), .compute_start(compute_start),
        .result_write(result_write), .result_ram_address(result_ram_address),
        .written_words(written_words), .pass_count(pass_count));

    initial forever #20 pclk = ~pclk;
    // slow clock runs free, phase unrelated to pclk
    initial forever #15259 slow_32k_clock = ~slow_32k_clock;

    // ========================================
    // checks and closing
    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_res(input logic [4:0] got, input logic [4:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ========================================
    // apb master
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic eer);
        apb(1'b0, a, 8'h00);
        chk_val(rd, exp);
        chk_val({31'h0, er}, {31'h0, eer});
    endtask

    // configuration first, slot count last, so nothing moves while it changes
    task automatic cfg(input logic [7:0] rem, mode, rate, s01, s23, cnt);
        apb(1'b1, amfs_pkg::ADDR_REMOTE, rem);
        apb(1'b1, amfs_pkg::ADDR_MODE, mode);
        apb(1'b1, amfs_pkg::ADDR_RATE, rate);
        apb(1'b1, amfs_pkg::ADDR_SEL_0_1, s01);
        apb(1'b1, amfs_pkg::ADDR_SEL_2_3, s23);
        apb(1'b1, amfs_pkg::ADDR_SLOT_COUNT, cnt);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 60000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 60000) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    // ========================================
    // result monitor
    always @(posedge pclk) begin
        if (presetn && result_write === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time,
                    {result_from_remote, result_ram_address}, 5'h1f);
            end else begin
                chk_res({result_from_remote, result_ram_address}, exp_q.pop_front());
            end
        end
    end

    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(amfs_pkg::ADDR_SLOT_COUNT, 32'h0000_0000, 1'b0);
        rdchk(amfs_pkg::ADDR_SEL_0_1, 32'h0000_0000, 1'b0);
        rdchk(amfs_pkg::ADDR_MODE, 32'h0000_0000, 1'b0);
        rdchk(amfs_pkg::ADDR_REMOTE, 32'h0000_0000, 1'b0);
        rdchk(16'h0000, 32'h0000_0000, 1'b1);
        r = $random(seed);
        apb(1'b1, amfs_pkg::ADDR_SEL_8_9, r[7:0]);
        rdchk(amfs_pkg::ADDR_SEL_8_9, {24'h00_0000, r[7:0]}, 1'b0);
        // differential pairs: handles 1 and 3 leave no result
        apb(1'b1, amfs_pkg::ADDR_CHOP, 8'h04);
        exp_q = '{5'h0a, 5'h0a};
        cfg(8'h00, 8'h32, 8'h10, 8'ha1, 8'h03, 8'h30);
        drain();
        apb(1'b1, amfs_pkg::ADDR_SLOT_COUNT, 8'h00);
        chk_val({pass_count, 20'h0_0000, written_words[3], written_words[1], 1'b0,
            reference_chop_phase}, 32'h0200_0001);
        // remote mode, half rate: slot two dropped, remote sample to word two
        exp_q = '{5'h00, 5'h12, 5'h0a};
        cfg(8'h08, 8'h12, 8'h30, 8'ha0, 8'h11, 8'h30);
        drain();
        // slot two running: parked handle, latched rate and mode bits
        chk_val({22'h0, slot_input_select, converter_half_rate, fast_pll_select,
            frame_active, remote_sensor_enable, pair_a_differential,
            pair_b_differential}, 32'h0000_007e);
        rdchk(amfs_pkg::ADDR_FRAME_SLOW, 32'h0000_000d, 1'b0);
        rdchk(amfs_pkg::ADDR_FRAME_FILTER, 32'h0000_079e, 1'b0);
        apb(1'b1, amfs_pkg::ADDR_SLOT_COUNT, 8'h00);
        // four single-ended slots, longer decimation
        exp_q = '{5'h00, 5'h0a, 5'h03, 5'h09};
        cfg(8'h00, 8'h04, 8'h30, 8'ha0, 8'h93, 8'h40);
        drain();
        rdchk(amfs_pkg::ADDR_FRAME_SLOW, 32'h0000_0019, 1'b0);
        rdchk(amfs_pkg::ADDR_FRAME_FILTER, 32'h0000_0ea6, 1'b0);
        apb(1'b1, amfs_pkg::ADDR_SLOT_COUNT, 8'h00);
        print_verdict();
    end
endmodule // testbench
